// ==== anpas_consts.svh ====
`ifndef ANPAS_CONSTS_SVH
`define ANPAS_CONSTS_SVH

`define ANPAS_ADDR_W        5
`define ANPAS_DATA_W        16
`define ANPAS_OFS_ABILITY   5'h05
`define ANPAS_OFS_EXPANSION 5'h06
`define ANPAS_OFS_NEXT_PAGE 5'h08

`define ANPAS_ABIL_RESET    16'h0000
`define ANPAS_NP_RESET      16'h0000
`define ANPAS_ABIL_RSVD_BIT 12

`define ANPAS_EXP_BASE_PAGE 5
`define ANPAS_EXP_PD_FAULT  4
`define ANPAS_EXP_LP_NP     3
`define ANPAS_EXP_LOC_NP    2
`define ANPAS_EXP_PAGE_RX   1
`define ANPAS_EXP_LP_AN     0
`define ANPAS_EXP_RSVD_MSB  15
`define ANPAS_EXP_RSVD_LSB  6
`define ANPAS_LOC_NP_ABLE   1'h1

`define ANPAS_FL_COUNT      3
`define ANPAS_FL_PAGE       0
`define ANPAS_FL_PDF        1
`define ANPAS_FL_BASE       2

`endif

// ==== anpas_pkg.sv ====
package anpas_pkg;

	typedef struct packed {
		logic        valid;
		logic        base;
		logic [15:0] word;
	} anpas_page_evt_t;

	typedef struct packed {
		logic lp_an_able;
		logic lp_np_able;
	} anpas_lp_status_t;

endpackage

// ==== anpas_lh_bit.sv ====
`timescale 1ns/1ns
`default_nettype none

module anpas_flag_bit (
	input  wire logic mclk_i,
	input  wire logic srst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output var  logic q_o
);

	logic q_r;
	logic q_nxt;

	// Set beats clear so an event in the clearing cycle survives
	always_comb begin
		q_nxt = set_i | (q_r & ~clr_i);
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			q_r <= 1'h0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;

endmodule

`default_nettype wire

// ==== anpas_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

`include "anpas_consts.svh"

// Summary of operation
// - Bit 15 shows partner next page ability
// - Bit 14 shows partner acknowledge
// - Bit 13 shows partner remote fault
// - Bits 11,10 show asymmetric pause, pause
// - Bits 9..5 show partner technology abilities
// - Bits 4..0 hold received selector code
// - Expansion bit 4 latches parallel detection fault
// - Expansion bit 3 shows partner next page ability
// - Expansion bit 2 always reads one
// - Page received latches, clears on expansion read
// - Alternate mode: also clear on abort conditions
// - Load code word before raising page flag
// - Expansion bit 0 shows partner autonegotiation able
module anpas_regs (
	input  wire logic                         mclk_i,
	input  wire logic                         srst_i,
	input  wire logic                         rd_en_i,
	input  wire logic [`ANPAS_ADDR_W-1:0]     rd_addr_i,
	output var  logic [`ANPAS_DATA_W-1:0]     rd_data_o,
	output var  logic                         rd_valid_o,
	input  wire anpas_pkg::anpas_page_evt_t   page_evt_i,
	input  wire logic                         par_det_fault_i,
	input  wire anpas_pkg::anpas_lp_status_t  lp_status_i,
	input  wire logic                         mr_page_rx_i,
	input  wire logic                         transmit_disable_i,
	input  wire logic                         alternate_next_page_mode_i,
	output var  logic [`ANPAS_DATA_W-1:0]     lp_next_page_word_o
);

	// Page capture group
	logic [`ANPAS_DATA_W-1:0] abil_r;
	logic [`ANPAS_DATA_W-1:0] abil_nxt;
	logic [`ANPAS_DATA_W-1:0] np_r;
	logic [`ANPAS_DATA_W-1:0] np_nxt;
	logic                     pend_r;
	logic                     pend_nxt;
	logic                     pend_base_r;
	logic                     pend_base_nxt;

	// Live status and edge history group
	anpas_pkg::anpas_lp_status_t sts_r;
	anpas_pkg::anpas_lp_status_t sts_nxt;
	logic                        page_rx_q_r;
	logic                        page_rx_q_nxt;
	logic                        tx_dis_q_r;
	logic                        tx_dis_q_nxt;

	// Read port group
	logic [`ANPAS_DATA_W-1:0] rd_data_r;
	logic [`ANPAS_DATA_W-1:0] rd_data_nxt;
	logic                     rd_valid_r;
	logic                     rd_valid_nxt;
	logic [`ANPAS_ADDR_W-1:0] rd_addr_q_r;
	logic [`ANPAS_ADDR_W-1:0] rd_addr_q_nxt;

	// Latching-high cells
	logic [`ANPAS_FL_COUNT-1:0] fl_set;
	logic [`ANPAS_FL_COUNT-1:0] fl_clr;
	logic [`ANPAS_FL_COUNT-1:0] fl_q;

	logic exp_read;
	logic abort_clr;
	logic [`ANPAS_DATA_W-1:0] exp_word;

	assign exp_read = rd_en_i && (rd_addr_i == `ANPAS_OFS_EXPANSION);

	// Page capture: word lands first, flag follows one cycle later
	always_comb begin
		abil_nxt      = abil_r;
		np_nxt        = np_r;
		pend_nxt      = page_evt_i.valid;
		pend_base_nxt = page_evt_i.valid & page_evt_i.base;
		if (page_evt_i.valid) begin
			if (page_evt_i.base) begin
				// Whole base page, selector kept as received
				abil_nxt = page_evt_i.word;
				// Reserved position never reflects line content
				abil_nxt[`ANPAS_ABIL_RSVD_BIT] = 1'h0;
			end else begin
				np_nxt = page_evt_i.word;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			abil_r      <= `ANPAS_ABIL_RESET;
			np_r        <= `ANPAS_NP_RESET;
			pend_r      <= 1'h0;
			pend_base_r <= 1'h0;
		end else begin
			abil_r      <= abil_nxt;
			np_r        <= np_nxt;
			pend_r      <= pend_nxt;
			pend_base_r <= pend_base_nxt;
		end
	end

	// Inputs come from autonegotiation logic on this clock, no sync
	always_comb begin
		sts_nxt       = lp_status_i;
		page_rx_q_nxt = mr_page_rx_i;
		tx_dis_q_nxt  = transmit_disable_i;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sts_r       <= '0;
			page_rx_q_r <= 1'h0;
			tx_dis_q_r  <= 1'h0;
		end else begin
			sts_r       <= sts_nxt;
			page_rx_q_r <= page_rx_q_nxt;
			tx_dis_q_r  <= tx_dis_q_nxt;
		end
	end

	// Only transitions clear, a steady level does not keep clearing
	assign abort_clr = alternate_next_page_mode_i &&
		((page_rx_q_r && !mr_page_rx_i) ||
		 (!tx_dis_q_r && transmit_disable_i));

	always_comb begin
		fl_set = '0;
		fl_clr = '0;
		fl_set[`ANPAS_FL_PAGE] = pend_r;
		fl_clr[`ANPAS_FL_PAGE] = exp_read | abort_clr;
		fl_set[`ANPAS_FL_PDF]  = par_det_fault_i;
		fl_clr[`ANPAS_FL_PDF]  = exp_read;
		fl_set[`ANPAS_FL_BASE] = pend_base_r;
		fl_clr[`ANPAS_FL_BASE] = exp_read;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `ANPAS_FL_COUNT; gi = gi + 1) begin : g_flag
			anpas_flag_bit u_flag (
				.mclk_i (mclk_i),
				.srst_i (srst_i),
				.set_i  (fl_set[gi]),
				.clr_i  (fl_clr[gi]),
				.q_o    (fl_q[gi])
			);
		end
	endgenerate

	always_comb begin
		exp_word = '0;
		exp_word[`ANPAS_EXP_BASE_PAGE] = fl_q[`ANPAS_FL_BASE];
		exp_word[`ANPAS_EXP_PD_FAULT]  = fl_q[`ANPAS_FL_PDF];
		exp_word[`ANPAS_EXP_LP_NP]     = sts_r.lp_np_able;
		exp_word[`ANPAS_EXP_LOC_NP]    = `ANPAS_LOC_NP_ABLE;
		exp_word[`ANPAS_EXP_PAGE_RX]   = fl_q[`ANPAS_FL_PAGE];
		exp_word[`ANPAS_EXP_LP_AN]     = sts_r.lp_an_able;
	end

	// Read returns the pre-clear value; the clear lands on the same edge
	always_comb begin
		rd_data_nxt   = rd_data_r;
		rd_valid_nxt  = rd_en_i;
		rd_addr_q_nxt = rd_addr_q_r;
		if (rd_en_i) begin
			rd_addr_q_nxt = rd_addr_i;
			unique case (rd_addr_i)
				`ANPAS_OFS_ABILITY:   rd_data_nxt = abil_r;
				`ANPAS_OFS_EXPANSION: rd_data_nxt = exp_word;
				`ANPAS_OFS_NEXT_PAGE: rd_data_nxt = np_r;
				default:              rd_data_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_data_r   <= '0;
			rd_valid_r  <= 1'h0;
			rd_addr_q_r <= '0;
		end else begin
			rd_data_r   <= rd_data_nxt;
			rd_valid_r  <= rd_valid_nxt;
			rd_addr_q_r <= rd_addr_q_nxt;
		end
	end

	assign rd_data_o           = rd_data_r;
	assign rd_valid_o          = rd_valid_r;
	assign lp_next_page_word_o = np_r;

	property p_base_load;
		@(posedge mclk_i) disable iff (srst_i)
		(page_evt_i.valid && page_evt_i.base) |=>
			(abil_r[15:13] == $past(page_evt_i.word[15:13])) &&
			(abil_r[11:0] == $past(page_evt_i.word[11:0]));
	endproperty
	a_base_load: assert property (p_base_load)
		else $error("ability register not loaded from base page");

	property p_flag_after_load;
		@(posedge mclk_i) disable iff (srst_i)
		page_evt_i.valid |=> !$past(fl_q[`ANPAS_FL_PAGE]) |->
			##1 fl_q[`ANPAS_FL_PAGE];
	endproperty
	a_flag_after_load: assert property (p_flag_after_load)
		else $error("page flag not raised two cycles after page");

	property p_clear_on_read;
		@(posedge mclk_i) disable iff (srst_i)
		(exp_read && !fl_set[`ANPAS_FL_PAGE]) |=>
			!fl_q[`ANPAS_FL_PAGE];
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("page flag survived expansion read");

	property p_hold_pdf;
		@(posedge mclk_i) disable iff (srst_i)
		(fl_q[`ANPAS_FL_PDF] && !exp_read) |=> fl_q[`ANPAS_FL_PDF];
	endproperty
	a_hold_pdf: assert property (p_hold_pdf)
		else $error("latched fault dropped without a read");

	// A read in the next cycle is legal, so it must not be part of this
	property p_pdf_set;
		@(posedge mclk_i) disable iff (srst_i)
		par_det_fault_i |=> fl_q[`ANPAS_FL_PDF];
	endproperty
	a_pdf_set: assert property (p_pdf_set)
		else $error("parallel detection fault not latched");

	property p_hold_base;
		@(posedge mclk_i) disable iff (srst_i)
		(fl_q[`ANPAS_FL_BASE] && !exp_read) |=> fl_q[`ANPAS_FL_BASE];
	endproperty
	a_hold_base: assert property (p_hold_base)
		else $error("base page flag dropped without a read");

	property p_base_flag;
		@(posedge mclk_i) disable iff (srst_i)
		(page_evt_i.valid && page_evt_i.base) |=> ##1
			fl_q[`ANPAS_FL_BASE];
	endproperty
	a_base_flag: assert property (p_base_flag)
		else $error("base page flag not raised");

	property p_np_load;
		@(posedge mclk_i) disable iff (srst_i)
		(page_evt_i.valid && !page_evt_i.base) |=>
			(np_r == $past(page_evt_i.word));
	endproperty
	a_np_load: assert property (p_np_load)
		else $error("next page register not loaded");

	property p_abort_clear;
		@(posedge mclk_i) disable iff (srst_i)
		(alternate_next_page_mode_i && $fell(mr_page_rx_i) &&
			!pend_r) |=> !fl_q[`ANPAS_FL_PAGE];
	endproperty
	a_abort_clear: assert property (p_abort_clear)
		else $error("page flag not cleared on page abort");

	property p_tx_dis_clear;
		@(posedge mclk_i) disable iff (srst_i)
		(alternate_next_page_mode_i && $rose(transmit_disable_i) &&
			!pend_r) |=> !fl_q[`ANPAS_FL_PAGE];
	endproperty
	a_tx_dis_clear: assert property (p_tx_dis_clear)
		else $error("page flag not cleared on transmit disable");

	property p_abil_read;
		@(posedge mclk_i) disable iff (srst_i)
		(rd_en_i && rd_addr_i == `ANPAS_OFS_ABILITY) |=>
			rd_valid_o && (rd_data_o == $past(abil_r));
	endproperty
	a_abil_read: assert property (p_abil_read)
		else $error("ability read does not match register");

	property p_local_np;
		@(posedge mclk_i) disable iff (srst_i)
		(rd_valid_o && rd_addr_q_r == `ANPAS_OFS_EXPANSION) |->
			rd_data_o[`ANPAS_EXP_LOC_NP] &&
			(rd_data_o[`ANPAS_EXP_RSVD_MSB:`ANPAS_EXP_RSVD_LSB] == '0);
	endproperty
	a_local_np: assert property (p_local_np)
		else $error("expansion read shows bad fixed bits");

	property p_lp_an;
		@(posedge mclk_i) disable iff (srst_i)
		(rd_en_i && rd_addr_i == `ANPAS_OFS_EXPANSION) ##1 1'h1 |->
			rd_data_o[`ANPAS_EXP_LP_AN] == $past(sts_r.lp_an_able);
	endproperty
	a_lp_an: assert property (p_lp_an)
		else $error("partner autonegotiation ability misreported");

	property p_lp_np;
		@(posedge mclk_i) disable iff (srst_i)
		(rd_en_i && rd_addr_i == `ANPAS_OFS_EXPANSION) |=>
			rd_data_o[`ANPAS_EXP_LP_NP] == $past(sts_r.lp_np_able);
	endproperty
	a_lp_np: assert property (p_lp_np)
		else $error("partner next page ability misreported");

endmodule

`default_nettype wire

// ==== anpas_lp_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module anpas_lp_model (
	input  wire logic                        mclk_i,
	output var  anpas_pkg::anpas_page_evt_t  page_evt_o,
	output var  anpas_pkg::anpas_lp_status_t lp_status_o
);
	initial begin
		page_evt_o  = '0;
		lp_status_o = '0;
	end

	task automatic set_status(input logic an, input logic np);
		lp_status_o <= '{lp_an_able: an, lp_np_able: np};
	endtask

	task automatic send(input logic base, input logic [15:0] word);
		// Reserved selectors are never put on the wire
		if (base && (word[4:0] == 5'h00 || word[4:0] == 5'h1f)) begin
			return;
		end
		@(posedge mclk_i);
		page_evt_o <= '{valid: 1'h1, base: base, word: word};
		@(posedge mclk_i);
		// Stale contents inverted so a late capture cannot pass
		page_evt_o <= '{valid: 1'h0, base: ~base, word: ~word};
	endtask
endmodule

`default_nettype wire

// ==== anpas_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module anpas_regs_tb;
	logic                        mclk_i;
	logic                        srst_i;
	logic                        rd_en_i;
	logic [4:0]                  rd_addr_i;
	logic [15:0]                 rd_data_o;
	logic [15:0]                 np_word;
	logic                        rd_valid_o;
	logic                        fault_r;
	logic                        mr_page_rx_r;
	logic                        tx_dis_r;
	logic                        alt_r;
	anpas_pkg::anpas_page_evt_t  page_evt;
	anpas_pkg::anpas_lp_status_t lp_status;
	int                          err_count;
	int                          total_checks;

	anpas_regs i_anpas_regs (
		.mclk_i                     (mclk_i),
		.srst_i                     (srst_i),
		.rd_en_i                    (rd_en_i),
		.rd_addr_i                  (rd_addr_i),
		.rd_data_o                  (rd_data_o),
		.rd_valid_o                 (rd_valid_o),
		.page_evt_i                 (page_evt),
		.par_det_fault_i            (fault_r),
		.lp_status_i                (lp_status),
		.mr_page_rx_i               (mr_page_rx_r),
		.transmit_disable_i         (tx_dis_r),
		.alternate_next_page_mode_i (alt_r),
		.lp_next_page_word_o        (np_word)
	);

	anpas_lp_model i_anpas_lp_model (
		.mclk_i      (mclk_i),
		.page_evt_o  (page_evt),
		.lp_status_o (lp_status)
	);

	initial begin
		mclk_i = 1'h0;
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic stop_test;
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge mclk_i);
		rd_en_i   <= 1'h1;
		rd_addr_i <= a;
		@(posedge mclk_i);
		rd_en_i <= 1'h0;
		// Valid stands one cycle only: look just after the taking edge
		#1;
		total_checks++;
		if (rd_valid_o !== 1'h1 || rd_data_o !== exp) begin
			err_count++;
			$display("wrong value at %0t: addr %h got %h want %h",
				$time, a, rd_data_o, exp);
		end
	endtask

	// Two edges of settling so the flag is up before the read is taken
	task automatic pg(input logic base, input logic [15:0] word);
		i_anpas_lp_model.send(base, word);
		repeat (2) @(posedge mclk_i);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	initial begin
		logic [15:0] w;
		err_count    = 0;
		total_checks = 0;
		srst_i       = 1'h1;
		rd_en_i      = 1'h0;
		rd_addr_i    = 5'h00;
		fault_r      = 1'h0;
		mr_page_rx_r = 1'h0;
		tx_dis_r     = 1'h0;
		alt_r        = 1'h0;
		wait_n(8);
		srst_i <= 1'h0;
		rd(5'h05, 16'h0000);
		rd(5'h06, 16'h0004);
		rd(5'h1f, 16'h0000);
		i_anpas_lp_model.set_status(1'h1, 1'h1);
		pg(1'h1, 16'hffe1);
		rd(5'h05, 16'hefe1);
		for (int i = 5; i < 16; i++) begin
			w = (16'h0001 << i) | 16'h0002;
			pg(1'h1, w);
			rd(5'h05, (i == 12) ? 16'h0002 : w);
		end
		rd(5'h06, 16'h002f);
		rd(5'h06, 16'h000d);
		@(posedge mclk_i);
		fault_r <= 1'h1;
		@(posedge mclk_i);
		fault_r <= 1'h0;
		wait_n(2);
		rd(5'h06, 16'h001d);
		rd(5'h06, 16'h000d);
		pg(1'h0, 16'h1234);
		rd(5'h08, 16'h1234);
		total_checks++;
		if (np_word !== 16'h1234) begin
			err_count++;
			$display("wrong value at %0t: next page word %h",
				$time, np_word);
		end
		rd(5'h06, 16'h000f);
		alt_r        <= 1'h1;
		mr_page_rx_r <= 1'h1;
		pg(1'h0, 16'h0a5a);
		mr_page_rx_r <= 1'h0;
		wait_n(3);
		rd(5'h06, 16'h000d);
		mr_page_rx_r <= 1'h1;
		pg(1'h0, 16'h05a5);
		tx_dis_r <= 1'h1;
		wait_n(3);
		rd(5'h06, 16'h000d);
		tx_dis_r <= 1'h0;
		i_anpas_lp_model.set_status(1'h0, 1'h0);
		wait_n(2);
		rd(5'h06, 16'h0004);
		stop_test();
	end

	initial begin
		wait_n(3000);
		err_count++;
		stop_test();
	end
endmodule

`default_nettype wire
